// file: smsu_defines.vh
// Constants for the signed multiply and saturate unit: offsets, fields, codes.
// Assumes inclusion by bare name from the unit's design file.
`ifndef SMSU_DEFINES_VH
`define SMSU_DEFINES_VH

// Register byte offsets
`define SMSU_OFF_OPA        8'h00
`define SMSU_OFF_OPB        8'h04
`define SMSU_OFF_CMD        8'h08
`define SMSU_OFF_CFG        8'h0C
`define SMSU_OFF_RES_LO     8'h10
`define SMSU_OFF_RES_HI     8'h14
`define SMSU_OFF_STATUS     8'h18

// Command word fields
`define SMSU_CMD_OP_HI      2
`define SMSU_CMD_OP_LO      0
`define SMSU_CMD_SEL_BIT    3
`define SMSU_CMD_SAT_HI     8
`define SMSU_CMD_SAT_LO     4
`define SMSU_CMD_SHT_BIT    9
`define SMSU_CMD_AMT_HI     14
`define SMSU_CMD_AMT_LO     10
`define SMSU_CMD_PASS_BIT   15

// Operation codes
`define SMSU_OP_LONG_MUL    3'h0
`define SMSU_OP_WORD_HALF   3'h1
`define SMSU_OP_DUAL_MSUB   3'h2
`define SMSU_OP_SINGLE_SAT  3'h3
`define SMSU_OP_DUAL_SAT    3'h4
`define SMSU_OP_XCH_SUBADD  3'h5

// Configuration and status fields
`define SMSU_CFG_DSP_BIT    0
`define SMSU_ST_SAT_BIT     0
`define SMSU_ST_GE_HI       4
`define SMSU_ST_GE_LO       1
`define SMSU_ST_UNDEF_BIT   5

// Reset values
`define SMSU_RST_WORD       32'h00000000
`define SMSU_RST_CFG        32'h00000001
`define SMSU_RST_DSP        1'b1
`define SMSU_RST_GE         4'h0

`endif

// file: smsu_core.v
// Signed multiply and saturate unit with an APB register front end.
// Assumes an APB master on pclk; operands are written first, then a
// command word triggers one instruction with its condition-pass bit.
//
// Function
// RQ1 - Long multiply forms the full signed 64-bit product, low word to low, high word to high.
// RQ2 - Issuer must not use equal destinations or registers 13 and 15 for a long multiply.
// RQ3 - Long multiply never changes any condition flag.
// RQ4 - Word-by-halfword takes the top half of operand two when the select bit is one, else bottom.
// RQ5 - Word-by-halfword writes bits 47 to 16 of the signed 48-bit product.
// RQ6 - Word-by-halfword leaves the saturation flag unchanged.
// RQ7 - Dual multiply-subtract optionally rotates operand two by 16, then bottom minus top product.
// RQ8 - Single saturate shifts without carry, clamps to width field plus one and sign-extends.
// RQ9 - Pre-saturation shift is left by 0 to 31 or arithmetic right by 1 to 31 by shift type.
// RQ10 - Shift type set with zero amount is dual saturate with the extension, else undefined.
// RQ11 - Issuer must not name registers 13 or 15 for saturate or halfword multiplies.
// RQ12 - Dual saturate clamps each 16-bit half to 1 to 16 bits, sign-extended in its lane.
// RQ13 - Any actual clamp sets the saturation flag, otherwise it is left alone.
// RQ14 - Exchange subtract/add swaps operand two halves, adds and subtracts, sets the GE flags.
// RQ15 - Low lane is low first half plus high second half; high lane is high minus low.
// RQ16 - Low GE pair follows the sum sign, high GE pair follows the difference sign.
// RQ17 - Nothing updates unless the condition passes; the saturation flag is sticky.
//
// The placing of the registers and register access over APB were left to the implementer.
`include "smsu_defines.vh"
`timescale 1ns/1ps

module smsu_core (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Write-back view
  output reg  [31:0] res_lo,
  output reg  [31:0] res_hi,
  output reg         sat_flag,
  output reg  [3:0]  ge_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturation helper: bit 32 reports a clamp
  function [32:0] sat_fn;
    input [31:0] v;
    input [5:0]  n;
    reg   [31:0] hi;
    reg   [31:0] mx;

    begin
      hi = $signed(v) >>> (n - 6'h01);
      mx = (32'h00000001 << (n - 6'h01)) - 32'h00000001;
      // In range when every bit above the target sign agrees
      if ((hi == 32'h00000000) || (hi == 32'hFFFFFFFF)) begin
        sat_fn = {1'b0, v};
      end else if (v[31]) begin
        sat_fn = {1'b1, ~mx};
      end else begin
        sat_fn = {1'b1, mx};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [31:0] opa_q;
  reg  [31:0] opa_d;
  reg  [31:0] opb_q;
  reg  [31:0] opb_d;
  reg  [31:0] cmd_q;
  reg  [31:0] cmd_d;
  reg         dsp_q;
  reg         dsp_d;
  reg         undef_q;
  reg         undef_d;

  // Next values of the write-back outputs
  reg  [31:0] res_lo_d;
  reg  [31:0] res_hi_d;
  reg         sat_d;
  reg  [3:0]  ge_d;

  // Bus read path
  reg  [31:0] rdata_d;
  reg         addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  // Access phase takes two cycles: pready rises on the second one
  wire        acc_first = psel & penable & ~pready;
  wire        acc_done  = psel & penable & pready;
  wire        wr_en     = acc_done & pwrite & addr_ok;
  wire        wr_opa    = wr_en & (paddr == `SMSU_OFF_OPA);
  wire        wr_opb    = wr_en & (paddr == `SMSU_OFF_OPB);
  wire        wr_cmd    = wr_en & (paddr == `SMSU_OFF_CMD);
  wire        wr_cfg    = wr_en & (paddr == `SMSU_OFF_CFG);
  wire        wr_st     = wr_en & (paddr == `SMSU_OFF_STATUS);

  always @* begin
    addr_ok = 1'b1;
    rdata_d = `SMSU_RST_WORD;
    case (paddr)
      `SMSU_OFF_OPA: begin
        rdata_d = opa_q;
      end
      `SMSU_OFF_OPB: begin
        rdata_d = opb_q;
      end
      `SMSU_OFF_CMD: begin
        rdata_d = cmd_q;
      end
      `SMSU_OFF_CFG: begin
        rdata_d = {31'h00000000, dsp_q};
      end
      `SMSU_OFF_RES_LO: begin
        rdata_d = res_lo;
      end
      `SMSU_OFF_RES_HI: begin
        rdata_d = res_hi;
      end
      `SMSU_OFF_STATUS: begin
        rdata_d = {26'h0000000, undef_q, ge_flags, sat_flag};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command fields, taken from the write data of the triggering write
  wire [2:0]  op      = pwdata[`SMSU_CMD_OP_HI:`SMSU_CMD_OP_LO];
  wire        sel_m   = pwdata[`SMSU_CMD_SEL_BIT];
  wire [4:0]  sat_imm = pwdata[`SMSU_CMD_SAT_HI:`SMSU_CMD_SAT_LO];
  wire        sh_type = pwdata[`SMSU_CMD_SHT_BIT];
  wire [4:0]  sh_amt  = pwdata[`SMSU_CMD_AMT_HI:`SMSU_CMD_AMT_LO];
  wire        passed  = pwdata[`SMSU_CMD_PASS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Multiplies
  reg  [15:0] half_sel;
  reg  [31:0] opb_rot;
  wire [63:0] long_prod = $signed(opa_q) * $signed(opb_q); // [RQ1]

  // The unused half of operand two never reaches the product
  always @* begin
    if (sel_m) begin
      half_sel = opb_q[31:16]; // [RQ4]
    end else begin
      half_sel = opb_q[15:0]; // [RQ4]
    end
  end

  wire [31:0] half_ext  = {{16{half_sel[15]}}, half_sel};
  wire [63:0] wh_prod   = $signed(opa_q) * $signed(half_ext);
  wire [31:0] wh_res    = wh_prod[47:16]; // [RQ5]

  // Exchange is a rotate of operand two by 16
  always @* begin
    if (sel_m) begin
      opb_rot = {opb_q[15:0], opb_q[31:16]}; // [RQ7]
    end else begin
      opb_rot = opb_q;
    end
  end

  wire [31:0] dm_p1     = $signed(opa_q[15:0]) * $signed(opb_rot[15:0]);
  wire [31:0] dm_p2     = $signed(opa_q[31:16]) * $signed(opb_rot[31:16]);
  wire [31:0] dm_res    = dm_p1 - dm_p2; // [RQ7]

  ////////////////////////////////////////////////////////////////////////////
  // Single saturate: carry never enters the shifter
  // Shifts kept apart so a mixed select cannot turn the right shift logical
  wire [31:0] sh_asr    = $signed(opa_q) >>> sh_amt; // [RQ9]
  wire [31:0] sh_lsl    = opa_q << sh_amt; // [RQ9]
  reg  [31:0] sh_val;

  always @* begin
    if (sh_type) begin
      sh_val = sh_asr;
    end else begin
      sh_val = sh_lsl;
    end
  end

  wire [32:0] ss_out    = sat_fn(sh_val, {1'b0, sat_imm} + 6'h01); // [RQ8]
  // Reserved encoding: ASR with zero amount redirects to the dual form
  wire        redirect  = sh_type & (sh_amt == 5'h00); // [RQ10]

  ////////////////////////////////////////////////////////////////////////////
  // Dual halfword saturate, one lane per loop pass
  // Only the low four width bits count; the lane limit is 16
  wire [31:0] ds_res;
  wire [1:0]  ds_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      wire [15:0] lane_in  = opa_q[16*g+15:16*g];
      wire [32:0] lane_out = sat_fn({{16{lane_in[15]}}, lane_in},
                                    {2'b00, sat_imm[3:0]} + 6'h01); // [RQ12]
      assign ds_res[16*g+15:16*g] = lane_out[15:0];
      assign ds_hit[g]            = lane_out[32];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Exchange subtract/add, 17-bit sums keep the true sign
  // Low lane adds the crossed half, high lane subtracts it

  // Lane results truncate; flags follow the untruncated sign
  wire [16:0] xs_sum  = {opa_q[15], opa_q[15:0]} + {opb_q[31], opb_q[31:16]}; // [RQ15]
  wire [16:0] xs_diff = {opa_q[31], opa_q[31:16]} - {opb_q[15], opb_q[15:0]}; // [RQ15]
  wire [31:0] xs_res  = {xs_diff[15:0], xs_sum[15:0]}; // [RQ14]
  wire [3:0]  xs_ge   = {{2{~xs_diff[16]}}, {2{~xs_sum[16]}}}; // [RQ16]

  ////////////////////////////////////////////////////////////////////////////
  // Write-back selection
  always @* begin
    opa_d    = opa_q;
    opb_d    = opb_q;
    cmd_d    = cmd_q;
    dsp_d    = dsp_q;
    undef_d  = undef_q;
    res_lo_d = res_lo;
    res_hi_d = res_hi;
    sat_d    = sat_flag;
    ge_d     = ge_flags;

    if (wr_opa) begin
      opa_d = pwdata;
    end

    if (wr_opb) begin
      opb_d = pwdata;
    end

    if (wr_cfg) begin
      dsp_d = pwdata[`SMSU_CFG_DSP_BIT];
    end

    // Write one to clear; a clamp in the same cycle wins below
    if (wr_st && pwdata[`SMSU_ST_SAT_BIT]) begin
      sat_d = 1'b0;
    end

    if (wr_st && pwdata[`SMSU_ST_UNDEF_BIT]) begin
      undef_d = 1'b0;
    end

    if (wr_cmd) begin
      cmd_d = pwdata;
    end

    // Failed condition leaves every result and flag as it was
    if (wr_cmd && passed) begin // [RQ17]
      case (op)
        `SMSU_OP_LONG_MUL: begin
          // Flags deliberately untouched
          res_lo_d = long_prod[31:0]; // [RQ1] [RQ3]
          res_hi_d = long_prod[63:32]; // [RQ1]
        end
        `SMSU_OP_WORD_HALF: begin
          res_lo_d = wh_res; // [RQ5] [RQ6]
        end
        `SMSU_OP_DUAL_MSUB: begin
          res_lo_d = dm_res; // [RQ7]
        end
        `SMSU_OP_SINGLE_SAT: begin
          if (redirect && dsp_q) begin
            res_lo_d = ds_res; // [RQ10]
            if (|ds_hit) begin
              sat_d = 1'b1; // [RQ13]
            end
          end else if (redirect) begin
            undef_d = 1'b1; // [RQ10]
          end else begin
            res_lo_d = ss_out[31:0]; // [RQ8]
            if (ss_out[32]) begin
              sat_d = 1'b1; // [RQ13]
            end
          end
        end
        `SMSU_OP_DUAL_SAT: begin
          if (dsp_q) begin
            res_lo_d = ds_res; // [RQ12]
            if (|ds_hit) begin
              sat_d = 1'b1; // [RQ13] [RQ17]
            end
          end else begin
            undef_d = 1'b1;
          end
        end
        `SMSU_OP_XCH_SUBADD: begin
          if (dsp_q) begin
            res_lo_d = xs_res; // [RQ14]
            ge_d     = xs_ge; // [RQ16]
          end else begin
            undef_d = 1'b1;
          end
        end
        default: begin
          undef_d = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and APB answer flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_q    <= `SMSU_RST_WORD;
      opb_q    <= `SMSU_RST_WORD;
      cmd_q    <= `SMSU_RST_WORD;
      dsp_q    <= `SMSU_RST_DSP;
      undef_q  <= 1'b0;
      res_lo   <= `SMSU_RST_WORD;
      res_hi   <= `SMSU_RST_WORD;
      sat_flag <= 1'b0;
      ge_flags <= `SMSU_RST_GE;
      prdata   <= `SMSU_RST_WORD;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else if (clk_en) begin
      opa_q    <= opa_d;
      opb_q    <= opb_d;
      cmd_q    <= cmd_d;
      dsp_q    <= dsp_d;
      undef_q  <= undef_d;
      res_lo   <= res_lo_d;
      res_hi   <= res_hi_d;
      sat_flag <= sat_d;
      ge_flags <= ge_d;
      pready   <= acc_first;
      pslverr  <= acc_first & ~addr_ok;
      if (acc_first && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

endmodule // smsu_core

// file: smsu_asserts.sv
// Checker for the multiply and saturate unit.
// Assumes binding to smsu_core; sees its ports only.
`include "smsu_defines.vh"
`timescale 1ns/1ps
module smsu_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  // Bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Write-back
  input wire [31:0] res_lo,
  input wire [31:0] res_hi,
  input wire        sat_flag,
  input wire [3:0]  ge_flags
);
  ////////////////////////////////////////
  wire       done = psel & penable & pready;
  wire       run  = done & pwrite & (paddr == `SMSU_OFF_CMD) & pwdata[15];
  wire [2:0] op   = pwdata[2:0];
  wire       satc = run & (op == `SMSU_OP_SINGLE_SAT | op == `SMSU_OP_DUAL_SAT);
  wire       clr  = done & pwrite & (paddr == `SMSU_OFF_STATUS) & pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Result may land one or two edges after the execute edge
  a_ready_next: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("pready missing after first access cycle");
  a_ready_pulse: assert property (clk_en && pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ge_pairs: assert property (ge_flags[1:0] != 2'h1 && ge_flags[1:0] != 2'h2 &&
    ge_flags[3:2] != 2'h1 && ge_flags[3:2] != 2'h2)
    else $error("flag pair split");
  a_ge_cause: assert property (!$stable(ge_flags) |->
    $past(run && op == `SMSU_OP_XCH_SUBADD) || $past(run && op == `SMSU_OP_XCH_SUBADD, 2))
    else $error("flags moved without exchange op");
  a_res_hi_cause: assert property (!$stable(res_hi) |->
    $past(run && op == `SMSU_OP_LONG_MUL) || $past(run && op == `SMSU_OP_LONG_MUL, 2))
    else $error("high word moved without long multiply");
  a_res_lo_cause: assert property (!$stable(res_lo) |-> $past(run) || $past(run, 2))
    else $error("low word moved without passed command");
  a_sat_rise_cause: assert property ($rose(sat_flag) |-> $past(satc) || $past(satc, 2))
    else $error("saturation flag set by wrong op");
  a_sat_sticky: assert property ($fell(sat_flag) |-> $past(clr) || $past(clr, 2))
    else $error("saturation flag cleared by instruction");
endmodule // smsu_asserts

bind smsu_core smsu_asserts u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .res_lo(res_lo),
  .res_hi(res_hi), .sat_flag(sat_flag), .ge_flags(ge_flags));

// file: smsu_host.sv
// Partner model: decode stage and register file as APB master.
// Assumes each call starts just after a rising edge of pclk.
`timescale 1ns/1ps
module smsu_host (
  // Clock
  input  wire        pclk,
  // Request
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  ////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Whole words only; no register numbers exist at this level
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only pready or the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // smsu_host

// file: tb_top.sv
// Self-checking bench for the multiply and saturate unit.
// Assumes smsu_core, smsu_host and the bound checker are compiled.
`include "smsu_defines.vh"
`timescale 1ns/1ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, x, g); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sat_flag, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, res_lo, res_hi, q;
  logic [3:0]  ge_flags;
  int          mismatches = 0, compares = 0, cycles = 0;
  ////////////////////////////////////////
  smsu_core dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .res_lo(res_lo), .res_hi(res_hi),
    .sat_flag(sat_flag), .ge_flags(ge_flags));
  smsu_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task wr(input [7:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input [7:0] a);
    u_host.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  function [31:0] cw(input [2:0] op, input sl, input [4:0] st, input sh, input [4:0] am);
    cw = {16'h0000, 1'b1, am, sh, st, sl, op};
  endfunction
  task run(input [31:0] a, input [31:0] b, input [31:0] c);
    wr(`SMSU_OFF_OPA, a);
    wr(`SMSU_OFF_OPB, b);
    wr(`SMSU_OFF_CMD, c);
    @(posedge pclk);
  endtask
  task t_mul;
    `CHK("reset", 1'b0, sat_flag)
    rd(`SMSU_OFF_CFG);
    `CHK("cfg", `SMSU_RST_CFG, q)
    run(32'hFFFFFFFE, 32'h7FFFFFFF, cw(`SMSU_OP_LONG_MUL, 0, 0, 0, 0));
    `CHK("lo", 32'h00000002, res_lo)
    `CHK("hi", 32'hFFFFFFFF, res_hi)
    `CHK("ge", 4'h0, ge_flags)
    run(32'h00010000, 32'h80000003, cw(`SMSU_OP_WORD_HALF, 1, 0, 0, 0));
    `CHK("wt", 32'hFFFF8000, res_lo)
    run(32'h00010000, 32'h80000003, cw(`SMSU_OP_WORD_HALF, 0, 0, 0, 0));
    `CHK("wb", 32'h00000003, res_lo)
    `CHK("q", 1'b0, sat_flag)
    run(32'h00020003, 32'h00050007, cw(`SMSU_OP_DUAL_MSUB, 0, 0, 0, 0));
    `CHK("ms", 32'h0000000B, res_lo)
    run(32'h00020003, 32'h00050007, cw(`SMSU_OP_DUAL_MSUB, 1, 0, 0, 0));
    `CHK("msx", 32'h00000001, res_lo)
  endtask
  task t_sat;
    run(32'h00000100, 0, cw(`SMSU_OP_SINGLE_SAT, 0, 7, 0, 0));
    `CHK("s8", 32'h0000007F, res_lo)
    `CHK("q", 1'b1, sat_flag)
    run(32'hFFFFF000, 0, cw(`SMSU_OP_SINGLE_SAT, 0, 15, 1, 4));
    `CHK("asr", 32'hFFFFFF00, res_lo)
    `CHK("q", 1'b1, sat_flag)
    wr(`SMSU_OFF_STATUS, 32'h00000001);
    run(32'h00000001, 0, cw(`SMSU_OP_SINGLE_SAT, 0, 31, 0, 31));
    `CHK("lsl", 32'h80000000, res_lo)
    `CHK("q", 1'b0, sat_flag)
    run(32'h80000005, 0, cw(`SMSU_OP_SINGLE_SAT, 0, 3, 1, 0));
    `CHK("d4", 32'hFFF80005, res_lo)
    `CHK("q", 1'b1, sat_flag)
    run(32'h80007FFF, 0, cw(`SMSU_OP_DUAL_SAT, 0, 15, 0, 0));
    `CHK("d16", 32'h80007FFF, res_lo)
    wr(`SMSU_OFF_CFG, 32'h00000000);
    run(32'h00001234, 0, cw(`SMSU_OP_SINGLE_SAT, 0, 3, 1, 0));
    `CHK("und", 32'h80007FFF, res_lo)
    rd(`SMSU_OFF_STATUS);
    `CHK("undf", 1'b1, q[`SMSU_ST_UNDEF_BIT])
    wr(`SMSU_OFF_CFG, 32'h00000001);
  endtask
  task t_xch;
    run(32'h00050002, 32'h00030004, cw(`SMSU_OP_XCH_SUBADD, 0, 0, 0, 0));
    `CHK("x1", 32'h00010005, res_lo)
    `CHK("g1", 4'hF, ge_flags)
    run(32'h80007FFF, 32'h00010001, cw(`SMSU_OP_XCH_SUBADD, 0, 0, 0, 0));
    `CHK("x2", 32'h7FFF8000, res_lo)
    `CHK("g2", 4'h3, ge_flags)
    run(32'h00000002, 32'h00000003, cw(`SMSU_OP_LONG_MUL, 0, 0, 0, 0) & ~32'h00008000);
    `CHK("np", 32'h7FFF8000, res_lo)
    `CHK("nph", 32'hFFFFFFFF, res_hi)
    rd(8'h1C);
    `CHK("err", 1'b1, e)
  endtask
  task wrap_up;
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_mul;
    t_sat;
    t_xch;
    wrap_up;
  end
endmodule // tb_top
